// File: common/lrt_params.svh
// Constants: register map, field positions, reset values and timing for the light result core
// Behaviour
// R1 - Period codes 0..11 select 0.6ms up to 800ms conversion periods.
// R2 - A conversion period runs from start until the result registers are written.
// R3 - Each result is a 4-bit range index plus a 20-bit linear fraction.
// R4 - Fraction splits into upper 12 bits and lower 8 bits: upper*256+lower.
// R5 - Range index holds the range really used, automatic or manual.
// R6 - Linear count is fraction shifted left by range index, 28 bits wide.
// R7 - High and low limits each hold a 12-bit fraction and 4-bit range index.
// R8 - Limits expand by shifting fraction left by eight plus range index.
// R9 - Count above high limit is a high event; below low limit a low event.
// R10 - Flags change only after the programmed number of consecutive events.
// R11 - Fault-count setting 2 demands four consecutive qualifying measurements.
// R12 - Only 9 plus period code fraction bits are kept; lower bits read zero.
// R13 - Near-infrared range index stops at 6; visible index may reach 8.
// R14 - Fraction and range fields of a channel update together per conversion.
`ifndef LRT_PARAMS_SVH
`define LRT_PARAMS_SVH

`define LRT_CLK_MHZ       25
`define LRT_T0_US         600
`define LRT_T1_US         1000
`define LRT_T2_US         1800
`define LRT_T3_US         3400
`define LRT_T4_US         6500
`define LRT_T5_US         12700
`define LRT_T6_US         25000
`define LRT_T7_US         50000
`define LRT_T8_US         100000
`define LRT_T9_US         200000
`define LRT_T10_US        400000
`define LRT_T11_US        800000
`define LRT_CODE_MAX      4'hb
`define LRT_BASE_BITS     9
`define LRT_FRAC_W        20
`define LRT_UPPER_W       12
`define LRT_LOWER_W       8
`define LRT_COUNT_W       28
`define LRT_LIM_W         36
`define LRT_VIS_RANGE_MAX 4'h8
`define LRT_NIR_RANGE_MAX 4'h6
`define LRT_RANGE_AUTO    4'hc

`define LRT_OFS_CONFIG    6'h00
`define LRT_OFS_THR_HI    6'h04
`define LRT_OFS_THR_LO    6'h08
`define LRT_OFS_CH0_UP    6'h0c
`define LRT_OFS_CH0_LOW   6'h10
`define LRT_OFS_CH1_UP    6'h14
`define LRT_OFS_CH1_LOW   6'h18
`define LRT_OFS_CH0_CNT   6'h1c
`define LRT_OFS_CH1_CNT   6'h20
`define LRT_OFS_INT_STAT  6'h24
`define LRT_OFS_INT_CLR   6'h28
`define LRT_OFS_INT_EN    6'h2c
`define LRT_OFS_FLAGS     6'h30

`define LRT_CFG_RUN       0
`define LRT_CFG_CODE_LSB  1
`define LRT_CFG_RANGE_LSB 5
`define LRT_CFG_FC_LSB    9
`define LRT_CFG_SEL_BIT   11
`define LRT_CFG_RESET     12'h180
`define LRT_THR_HI_RESET  16'hbfff
`define LRT_THR_LO_RESET  16'h0000
`define LRT_INT_W         4

`endif

// File: common/lrt_pkg.sv
// Types shared by the light result core
package lrt_pkg;
  typedef enum logic [1:0] {
    LRT_IDLE = 2'b00,
    LRT_CONV = 2'b01,
    LRT_LOAD = 2'b10
  } lrt_state_t;
endpackage

// File: rtl/lrt_fault_filter.sv
// Limit expansion, window compare and consecutive fault filtering
`include "lrt_params.svh"
module lrt_fault_filter (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    sample_valid,
  input  wire logic [`LRT_COUNT_W-1:0] count,
  input  wire logic [11:0]             hi_frac,
  input  wire logic [3:0]              hi_exp,
  input  wire logic [11:0]             lo_frac,
  input  wire logic [3:0]              lo_exp,
  input  wire logic [1:0]              fault_count,
  output logic                         flag_h,
  output logic                         flag_l
);
  logic [`LRT_LIM_W-1:0] hi_lim;
  logic [`LRT_LIM_W-1:0] lo_lim;
  logic [`LRT_LIM_W-1:0] cnt_wide;
  logic                  hi_evt;
  logic                  lo_evt;
  logic [3:0]            need;
  logic [3:0]            hcnt;
  logic [3:0]            lcnt;
  logic [3:0]            hok;
  logic [3:0]            lok;

  // Settings 0..3 need 1, 2, 4, 8 measurements in a row
  function automatic logic [3:0] decode_need(input logic [1:0] fc);
    decode_need = 4'h1 << fc; // R11
  endfunction

  assign need     = decode_need(fault_count); // R10
  // Zero-filled low bits; 36 bits so an exponent of 15 cannot overflow
  assign hi_lim   = {24'h000000, hi_frac} << (5'h08 + {1'b0, hi_exp}); // R8
  assign lo_lim   = {24'h000000, lo_frac} << (5'h08 + {1'b0, lo_exp}); // R8
  assign cnt_wide = {8'h00, count};
  assign hi_evt   = cnt_wide > hi_lim; // R9
  assign lo_evt   = cnt_wide < lo_lim; // R9

  // Run lengths saturate at need; a break in the run starts it over
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hcnt <= 4'h0;
      lcnt <= 4'h0;
      hok  <= 4'h0;
      lok  <= 4'h0;
    end
    else if (sample_valid)
    begin
      hcnt <= hi_evt ? ((hcnt >= need) ? need : hcnt + 4'h1) : 4'h0; // R10
      lcnt <= lo_evt ? ((lcnt >= need) ? need : lcnt + 4'h1) : 4'h0; // R10
      hok  <= !hi_evt ? ((hok >= need) ? need : hok + 4'h1) : 4'h0;
      lok  <= !lo_evt ? ((lok >= need) ? need : lok + 4'h1) : 4'h0;
    end
  end

  // Flags clear with the same hysteresis so a noisy edge cannot chatter them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_h <= 1'b0;
      flag_l <= 1'b0;
    end
    else if (sample_valid)
    begin
      if (hi_evt && hcnt + 4'h1 >= need)
        flag_h <= 1'b1; // R10
      else if (!hi_evt && hok + 4'h1 >= need)
        flag_h <= 1'b0;
      if (lo_evt && lcnt + 4'h1 >= need)
        flag_l <= 1'b1; // R10
      else if (!lo_evt && lok + 4'h1 >= need)
        flag_l <= 1'b0;
    end
  end

  a_hi_zero_fill: assert property (@(posedge clk) disable iff (!rst_n) // R8
    hi_lim[7:0] == 8'h00 && lo_lim[7:0] == 8'h00)
    else $error("limit low bits not zero filled");
  a_flag_h_run: assert property (@(posedge clk) disable iff (!rst_n) // R10
    sample_valid && hi_evt && hcnt == need - 4'h1 |=> flag_h)
    else $error("high flag not set after full run");
  a_four_needed: assert property (@(posedge clk) disable iff (!rst_n) // R11
    $rose(flag_h) && fault_count == 2'h2 |-> $past(hcnt) == 4'h3)
    else $error("high flag rose without four events");
  a_low_event: assert property (@(posedge clk) disable iff (!rst_n) // R9
    sample_valid && lo_evt && lcnt == need - 4'h1 |=> flag_l)
    else $error("low flag not set after full run");
endmodule // lrt_fault_filter

// File: rtl/lrt_core.sv
// Conversion timing, result formatting, register slave and interrupt logic
//
// Added by the designer: the address map and the Avalon-MM slave port.
`include "lrt_params.svh"
module lrt_core #(
  parameter int unsigned CYC_PER_US = `LRT_CLK_MHZ
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [5:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic [`LRT_FRAC_W-1:0]  meas_frac_vis,
  input  wire logic [`LRT_FRAC_W-1:0]  meas_frac_nir,
  input  wire logic [3:0]              auto_range_vis,
  input  wire logic [3:0]              auto_range_nir,
  output logic                         meas_chan,
  output logic                         irq
);
  lrt_pkg::lrt_state_t state;
  logic [11:0]              cfg;
  logic [15:0]              thr_hi;
  logic [15:0]              thr_lo;
  logic [`LRT_FRAC_W-1:0]   ch0_frac;
  logic [3:0]               ch0_range;
  logic [`LRT_COUNT_W-1:0]  ch0_count;
  logic [`LRT_FRAC_W-1:0]   ch1_frac;
  logic [3:0]               ch1_range;
  logic [`LRT_COUNT_W-1:0]  ch1_count;
  logic [31:0]              tick;
  logic [31:0]              period;
  logic                     ack;
  logic                     wr_go;
  logic                     rd_go;
  logic [3:0]               code;
  logic [3:0]               range_set;
  logic [3:0]               next_range;
  logic [`LRT_FRAC_W-1:0]   next_frac;
  logic                     cmp_valid;
  logic [`LRT_COUNT_W-1:0]  cmp_count;
  logic                     flag_h;
  logic                     flag_l;
  logic                     flag_h_d;
  logic                     flag_l_d;
  logic [`LRT_INT_W-1:0]    int_stat;
  logic [`LRT_INT_W-1:0]    int_en;
  logic [`LRT_INT_W-1:0]    int_evt;
  logic [`LRT_INT_W-1:0]    int_clr;
  logic [31:0]              wdata;
  logic [31:0]              cfg_m;
  logic [31:0]              thr_hi_m;
  logic [31:0]              thr_lo_m;

  // Conversion period in microseconds per code
  function automatic logic [31:0] period_us(input logic [3:0] c);
    case (c)
      4'h0:    period_us = `LRT_T0_US;
      4'h1:    period_us = `LRT_T1_US;
      4'h2:    period_us = `LRT_T2_US;
      4'h3:    period_us = `LRT_T3_US;
      4'h4:    period_us = `LRT_T4_US;
      4'h5:    period_us = `LRT_T5_US;
      4'h6:    period_us = `LRT_T6_US;
      4'h7:    period_us = `LRT_T7_US;
      4'h8:    period_us = `LRT_T8_US;
      4'h9:    period_us = `LRT_T9_US;
      4'ha:    period_us = `LRT_T10_US;
      default: period_us = `LRT_T11_US;
    endcase
  endfunction

  // Keeps the 9 + code top fraction bits; resolution below that is not real
  function automatic logic [`LRT_FRAC_W-1:0] frac_mask(input logic [3:0] c);
    logic [4:0] drop;
    drop      = 5'(`LRT_FRAC_W - `LRT_BASE_BITS) - {1'b0, c};
    frac_mask = {`LRT_FRAC_W{1'b1}} << drop;
  endfunction

  // Range used by a channel, bounded by how many ranges it has
  function automatic logic [3:0] pick_range(input logic [3:0] setting, input logic [3:0] autor,
                                            input logic [3:0] lim);
    logic [3:0] r;
    r          = (setting == `LRT_RANGE_AUTO) ? autor : setting;
    pick_range = (r > lim) ? lim : r;
  endfunction

  // Codes above 11 are held at the longest period
  assign code      = (cfg[`LRT_CFG_CODE_LSB+:4] > `LRT_CODE_MAX) ? `LRT_CODE_MAX
                                                                 : cfg[`LRT_CFG_CODE_LSB+:4];
  assign range_set = cfg[`LRT_CFG_RANGE_LSB+:4];
  assign period    = period_us(code) * CYC_PER_US; // R1

  always_comb
  begin
    if (meas_chan)
    begin
      next_range = pick_range(range_set, auto_range_nir, `LRT_NIR_RANGE_MAX); // R5 R13
      next_frac  = meas_frac_nir & frac_mask(code); // R12
    end
    else
    begin
      next_range = pick_range(range_set, auto_range_vis, `LRT_VIS_RANGE_MAX); // R5 R13
      next_frac  = meas_frac_vis & frac_mask(code); // R12
    end
  end

  // Timer runs to period-1 with the final cycle spent loading the result
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= lrt_pkg::LRT_IDLE;
      tick      <= 32'h0000_0000;
      meas_chan <= 1'b0;
    end
    else
    begin
      case (state)
        lrt_pkg::LRT_IDLE:
        begin
          tick <= 32'h0000_0000;
          if (cfg[`LRT_CFG_RUN])
            state <= lrt_pkg::LRT_CONV;
        end
        lrt_pkg::LRT_CONV:
        begin
          tick <= tick + 32'h0000_0001;
          if (tick >= period - 32'h0000_0002)
            state <= lrt_pkg::LRT_LOAD; // R2
        end
        lrt_pkg::LRT_LOAD:
        begin
          tick      <= 32'h0000_0000;
          meas_chan <= ~meas_chan;
          state     <= cfg[`LRT_CFG_RUN] ? lrt_pkg::LRT_CONV : lrt_pkg::LRT_IDLE;
        end
        default:
          state <= lrt_pkg::LRT_IDLE;
      endcase
    end
  end

  // Fraction, range and count move in one edge so a read never mixes two conversions
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch0_frac  <= 20'h00000;
      ch0_range <= 4'h0;
      ch0_count <= 28'h0000000;
      ch1_frac  <= 20'h00000;
      ch1_range <= 4'h0;
      ch1_count <= 28'h0000000;
    end
    else if (state == lrt_pkg::LRT_LOAD)
    begin
      if (meas_chan)
      begin
        ch1_frac  <= next_frac; // R3 R14
        ch1_range <= next_range; // R14
        ch1_count <= {8'h00, next_frac} << next_range; // R6
      end
      else
      begin
        ch0_frac  <= next_frac; // R3 R14
        ch0_range <= next_range; // R14
        ch0_count <= {8'h00, next_frac} << next_range; // R6
      end
    end
  end

  // The comparator watches the channel chosen in the configuration
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmp_valid <= 1'b0;
    else
      cmp_valid <= (state == lrt_pkg::LRT_LOAD) && (meas_chan == cfg[`LRT_CFG_SEL_BIT]);
  end

  assign cmp_count = cfg[`LRT_CFG_SEL_BIT] ? ch1_count : ch0_count;

  lrt_fault_filter u_filter (
    .clk          (clk),
    .rst_n        (rst_n),
    .sample_valid (cmp_valid),
    .count        (cmp_count),
    .hi_frac      (thr_hi[11:0]), // R7
    .hi_exp       (thr_hi[15:12]), // R7
    .lo_frac      (thr_lo[11:0]),
    .lo_exp       (thr_lo[15:12]),
    .fault_count  (cfg[`LRT_CFG_FC_LSB+:2]),
    .flag_h       (flag_h),
    .flag_l       (flag_l)
  );

  // One wait state per access: a read is taken on the cycle it shows and answered next; a write is taken on the next cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_go           = avs_write && ack;
  assign rd_go           = avs_read && !ack;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= (avs_read || avs_write) && !ack;
  end

  // Byte lanes merge into the old word so partial writes keep the other bytes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[8*i+:8] = be[i] ? nw[8*i+:8] : old[8*i+:8];
  endfunction

  assign wdata = avs_writedata;

  // Merged words are formed whole and cut to register width at the write
  assign cfg_m    = merge({20'h00000, cfg}, wdata, avs_byteenable);
  assign thr_hi_m = merge({16'h0000, thr_hi}, wdata, avs_byteenable);
  assign thr_lo_m = merge({16'h0000, thr_lo}, wdata, avs_byteenable);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg    <= `LRT_CFG_RESET;
      thr_hi <= `LRT_THR_HI_RESET;
      thr_lo <= `LRT_THR_LO_RESET;
      int_en <= 4'h0;
    end
    else if (wr_go)
    begin
      if (avs_address == `LRT_OFS_CONFIG)
        cfg <= cfg_m[11:0];
      else if (avs_address == `LRT_OFS_THR_HI)
        thr_hi <= thr_hi_m[15:0]; // R7
      else if (avs_address == `LRT_OFS_THR_LO)
        thr_lo <= thr_lo_m[15:0]; // R7
      else if (avs_address == `LRT_OFS_INT_EN && avs_byteenable[0])
        int_en <= wdata[`LRT_INT_W-1:0];
    end
  end

  // Events: visible done, infrared done, high flag rise, low flag rise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_h_d <= 1'b0;
      flag_l_d <= 1'b0;
    end
    else
    begin
      flag_h_d <= flag_h;
      flag_l_d <= flag_l;
    end
  end

  assign int_evt = {flag_l && !flag_l_d, flag_h && !flag_h_d,
                    state == lrt_pkg::LRT_LOAD && meas_chan,
                    state == lrt_pkg::LRT_LOAD && !meas_chan};
  assign int_clr = (wr_go && avs_address == `LRT_OFS_INT_CLR && avs_byteenable[0])
                   ? wdata[`LRT_INT_W-1:0] : 4'h0;

  // A new event beats a clear landing in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      int_stat <= 4'h0;
    else
      int_stat <= (int_stat & ~int_clr) | int_evt;
  end

  assign irq = |(int_stat & int_en);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (rd_go)
    begin
      if (avs_address == `LRT_OFS_CONFIG)
        avs_readdata <= {20'h00000, cfg};
      else if (avs_address == `LRT_OFS_THR_HI)
        avs_readdata <= {16'h0000, thr_hi};
      else if (avs_address == `LRT_OFS_THR_LO)
        avs_readdata <= {16'h0000, thr_lo};
      else if (avs_address == `LRT_OFS_CH0_UP)
        avs_readdata <= {16'h0000, ch0_range, ch0_frac[19:8]}; // R4
      else if (avs_address == `LRT_OFS_CH0_LOW)
        avs_readdata <= {24'h000000, ch0_frac[7:0]}; // R4
      else if (avs_address == `LRT_OFS_CH1_UP)
        avs_readdata <= {16'h0000, ch1_range, ch1_frac[19:8]}; // R4
      else if (avs_address == `LRT_OFS_CH1_LOW)
        avs_readdata <= {24'h000000, ch1_frac[7:0]}; // R4
      else if (avs_address == `LRT_OFS_CH0_CNT)
        avs_readdata <= {4'h0, ch0_count};
      else if (avs_address == `LRT_OFS_CH1_CNT)
        avs_readdata <= {4'h0, ch1_count};
      else if (avs_address == `LRT_OFS_INT_STAT)
        avs_readdata <= {28'h0000000, int_stat};
      else if (avs_address == `LRT_OFS_INT_EN)
        avs_readdata <= {28'h0000000, int_en};
      else if (avs_address == `LRT_OFS_FLAGS)
        avs_readdata <= {30'h00000000, flag_l, flag_h};
      else
        avs_readdata <= 32'h0000_0000;
    end
  end

  a_wait_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait state");
  a_period_end: assert property (@(posedge clk) disable iff (!rst_n) // R2
    state == lrt_pkg::LRT_CONV && tick == period - 32'h0000_0002 |=> state == lrt_pkg::LRT_LOAD)
    else $error("result load missed period end");
  a_code0_length: assert property (@(posedge clk) disable iff (!rst_n) // R1
    state == lrt_pkg::LRT_LOAD && code == 4'h0 |-> $past(tick) == period - 32'h0000_0002)
    else $error("period length wrong");
  a_nir_range: assert property (@(posedge clk) disable iff (!rst_n) // R13
    ch1_range <= `LRT_NIR_RANGE_MAX && ch0_range <= `LRT_VIS_RANGE_MAX)
    else $error("range index above channel limit");
  a_count_form: assert property (@(posedge clk) disable iff (!rst_n) // R6
    ch0_count == ({8'h00, ch0_frac} << ch0_range))
    else $error("linear count not fraction shifted by range");
  a_frac_resolve: assert property (@(posedge clk) disable iff (!rst_n) // R12
    state == lrt_pkg::LRT_LOAD && !meas_chan && $stable(cfg)
    |=> (ch0_frac & ~frac_mask(code)) == 20'h00000)
    else $error("unresolved fraction bits not zero");
  a_fields_together: assert property (@(posedge clk) disable iff (!rst_n) // R14
    $changed(ch0_range) |-> $past(state) == lrt_pkg::LRT_LOAD && !$past(meas_chan))
    else $error("range changed outside result load");
  a_manual_range: assert property (@(posedge clk) disable iff (!rst_n) // R5
    state == lrt_pkg::LRT_LOAD && !meas_chan && range_set <= `LRT_VIS_RANGE_MAX
    |=> ch0_range == $past(range_set))
    else $error("manual range not reported");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    int_evt[0] && int_en[0] |=> irq)
    else $error("enabled event gave no interrupt");
  a_set_beats_clr: assert property (@(posedge clk) disable iff (!rst_n)
    int_evt[1] |=> int_stat[1])
    else $error("new event lost to a clear");
  a_stat_vis_set: assert property (@(posedge clk) disable iff (!rst_n)
    int_evt[0] |=> int_stat[0])
    else $error("visible done event not recorded");
endmodule // lrt_core

// File: sim/lrt_host.sv
// Host controller model: Avalon-MM master for the light result core registers
module lrt_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  output logic [5:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    avs_address    = 6'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
  end

  // Waitrequest is taken at the rising edge, before that edge's own updates land
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // Released data bus shows the inverse, never a stale value
    avs_writedata <= ~d;
  endtask
endmodule // lrt_host

// File: sim/testbench.sv
// Self-checking bench for the light result core
`include "lrt_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [5:0]  a;
    logic [31:0] e;
  } lrt_row_t;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [19:0] meas_frac_vis;
  logic [19:0] meas_frac_nir;
  logic [3:0]  auto_range_vis;
  logic [3:0]  auto_range_nir;
  logic        meas_chan;
  logic        irq;
  logic [19:0] mv;
  logic [19:0] mn;
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  lrt_row_t    rows [7] = '{'{`LRT_OFS_CONFIG, 32'h180}, '{`LRT_OFS_THR_HI, 32'hbfff},
                            '{`LRT_OFS_THR_LO, 32'h0}, '{`LRT_OFS_INT_EN, 32'h0},
                            '{`LRT_OFS_INT_STAT, 32'h0}, '{`LRT_OFS_FLAGS, 32'h0},
                            '{6'h3c, 32'h0}};

  always #20 clk = ~clk;

  lrt_host host (
    .clk             (clk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
  );

  // One cycle per microsecond keeps code 0 at 600 cycles
  lrt_core #(.CYC_PER_US(1)) dut (
    .clk             (clk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .meas_frac_vis   (meas_frac_vis),
    .meas_frac_nir   (meas_frac_nir),
    .auto_range_vis  (auto_range_vis),
    .auto_range_nir  (auto_range_nir),
    .meas_chan       (meas_chan),
    .irq             (irq)
  );

  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask

  // Counts falling edges until the converted channel reaches v
  task automatic wait_chan(input logic v);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (meas_chan !== v && n < 3000);
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      results();
    end
  end

  initial
  begin
    meas_frac_vis  <= 20'habcde;
    meas_frac_nir  <= 20'h12345;
    auto_range_vis <= 4'h9;
    auto_range_nir <= 4'h7;
    // Code 0 keeps only the top nine fraction bits
    mv = 20'habcde & (20'hfffff << 11);
    mn = 20'h12345 & (20'hfffff << 11);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      rd_chk($sformatf("reset reg %h", rows[i].a), rows[i].a, rows[i].e);
    end
    $display("test reset values done");
    wr(`LRT_OFS_CONFIG, 32'h181);
    wait_chan(1'b1);
    // One idle cycle before the first conversion plus one for the falling-edge count
    chk("vis period", 32'(n), 32'd602);
    wait_chan(1'b0);
    chk("nir period", 32'(n), 32'd600);
    rd_chk("vis upper", `LRT_OFS_CH0_UP, {16'h0, 4'h8, mv[19:8]});
    rd_chk("vis lower", `LRT_OFS_CH0_LOW, {24'h0, mv[7:0]});
    rd_chk("vis count", `LRT_OFS_CH0_CNT, {4'h0, mv, 8'h0});
    rd_chk("nir upper", `LRT_OFS_CH1_UP, {16'h0, 4'h6, mn[19:8]});
    rd_chk("nir lower", `LRT_OFS_CH1_LOW, {24'h0, mn[7:0]});
    rd_chk("nir count", `LRT_OFS_CH1_CNT, {6'h0, mn, 6'h0});
    rd_chk("status done", `LRT_OFS_INT_STAT, 32'h3);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`LRT_OFS_INT_EN, 32'h3);
    @(negedge clk);
    chk("irq enabled", {31'h0, irq}, 32'h1);
    wr(`LRT_OFS_CONFIG, 32'h180);
    repeat (1300) @(negedge clk);
    // Status is read-only, so only the clear register may empty it
    wr(`LRT_OFS_INT_STAT, 32'hf);
    wr(`LRT_OFS_INT_CLR, 32'h3);
    rd_chk("status cleared", `LRT_OFS_INT_STAT, 32'h0);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test results and interrupts done");
    wr(`LRT_OFS_THR_HI, 32'h0001);
    wr(`LRT_OFS_THR_LO, 32'hffff);
    wr(`LRT_OFS_INT_EN, 32'hc);
    wr(`LRT_OFS_CONFIG, 32'h461);
    for (int k = 1; k <= 4; k++)
    begin
      wait_chan(1'b0);
      wait_chan(1'b1);
      repeat (3) @(negedge clk);
      rd_chk("flags", `LRT_OFS_FLAGS, (k == 4) ? 32'h3 : 32'h0);
    end
    rd_chk("manual range", `LRT_OFS_CH0_UP, {16'h0, 4'h3, mv[19:8]});
    @(negedge clk);
    chk("flag irq", {31'h0, irq}, 32'h1);
    $display("test fault filter done");
    // Code 1 keeps ten fraction bits and stretches the period to 1000 cycles
    wr(`LRT_OFS_CONFIG, 32'h183);
    mv = 20'habcde & (20'hfffff << 10);
    wait_chan(1'b0);
    wait_chan(1'b1);
    chk("code 1 period", 32'(n), 32'd1000);
    rd_chk("code 1 upper", `LRT_OFS_CH0_UP, {16'h0, 4'h8, mv[19:8]});
    $display("test second period code done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset chan", {31'h0, meas_chan}, 32'h0);
    chk("reset irq", {31'h0, irq}, 32'h0);
    rd_chk("reset config", `LRT_OFS_CONFIG, 32'h180);
    rd_chk("reset result", `LRT_OFS_CH0_UP, 32'h0);
    $display("test mid-run reset done");
    results();
  end
endmodule // testbench
